// *** hw/oem_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module oem_top (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst_n,
    // avalon-mm slave
    input  wire logic [oem_pkg::ADDR_W-1:0]  i_avs_address,
    input  wire logic                        i_avs_read,
    input  wire logic                        i_avs_write,
    input  wire logic [31:0]                 i_avs_writedata,
    output logic      [31:0]                 o_avs_readdata,
    output logic                             o_avs_waitrequest,
    // analyzer lookup
    input  wire logic                        i_ana_valid,
    input  wire logic [oem_pkg::PORT_W-1:0]  i_ana_port,
    input  wire logic [oem_pkg::SVC_W-1:0]   i_ana_service_index,
    input  wire logic                        i_ana_is_oam,
    input  wire logic                        i_ana_independent_level_flag,
    // rewriter lookup
    input  wire logic                        i_rew_valid,
    input  wire logic [oem_pkg::PORT_W-1:0]  i_rew_port,
    input  wire logic                        i_rew_egress_endpoint_index_valid,
    input  wire logic [oem_pkg::ENG_W-1:0]   i_rew_egress_endpoint_index,
    input  wire logic                        i_rew_is_oam,
    input  wire logic                        i_rew_independent_level_flag,
    // analyzer result
    output logic                             o_ana_done,
    output logic      [oem_pkg::ENG_W-1:0]   o_ana_active_engine,
    output logic                             o_ana_active_up,
    output logic                             o_ana_processed,
    output logic                             o_ana_discard,
    output logic                             o_ana_extract,
    // rewriter result
    output logic                             o_rew_done,
    output logic      [oem_pkg::ENG_W-1:0]   o_rew_active_engine,
    output logic                             o_rew_active_up,
    output logic                             o_rew_processed,
    output logic                             o_rew_discard,
    output logic                             o_rew_extract,
    // cpu queue for extracted pdus
    output logic      [oem_pkg::QUEUE_W-1:0] o_extract_queue
);
    localparam int NE = oem_pkg::NUM_ENG;
    localparam int NL = 2;  // lookup 0 = analyzer, 1 = rewriter

    // --------------------------------------------------------------------
    // configuration and counter storage
    // --------------------------------------------------------------------
    logic [oem_pkg::ENG_W_BITS-1:0] eng_q   [NE];
    logic [oem_pkg::SVC_W:0]        svc_q   [oem_pkg::NUM_SVC];
    logic [oem_pkg::CNT_W-1:0]      rx_q    [NE];
    logic [oem_pkg::CNT_W-1:0]      tx_q    [NE];
    logic [oem_pkg::CNT_W-1:0]      dsc_q   [NE];
    logic [oem_pkg::QUEUE_W-1:0]    queue_q;

    // --------------------------------------------------------------------
    // lookup input stage
    // --------------------------------------------------------------------
    logic                         lk_vld_q  [NL];
    logic [oem_pkg::PORT_W-1:0]   lk_port_q [NL];
    logic                         lk_map_q  [NL];
    logic [oem_pkg::ENG_W-1:0]    lk_idx_q  [NL];
    logic                         lk_data_q [NL];
    logic [oem_pkg::SVC_W:0]      ana_svc;

    // analyzer index comes from the service table, rewriter from action
    assign ana_svc = svc_q[i_ana_service_index];

    // capture both lookups; pdus with the level flag become data
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int l = 0; l < NL; l++) begin
                lk_vld_q[l]  <= 1'b0;
                lk_port_q[l] <= '0;
                lk_map_q[l]  <= 1'b0;
                lk_idx_q[l]  <= '0;
                lk_data_q[l] <= 1'b0;
            end
        end else begin
            lk_vld_q[0]  <= i_ana_valid;
            lk_port_q[0] <= i_ana_port;
            lk_map_q[0]  <= ana_svc[oem_pkg::SVC_ENA_BIT];
            lk_idx_q[0]  <= ana_svc[oem_pkg::SVC_IDX_LSB +: oem_pkg::ENG_W];
            lk_data_q[0] <= !i_ana_is_oam
                            || i_ana_independent_level_flag;
            lk_vld_q[1]  <= i_rew_valid;
            lk_port_q[1] <= i_rew_port;
            lk_map_q[1]  <= i_rew_egress_endpoint_index_valid;
            lk_idx_q[1]  <= i_rew_egress_endpoint_index;
            lk_data_q[1] <= !i_rew_is_oam
                            || i_rew_independent_level_flag;
        end
    end

    // --------------------------------------------------------------------
    // hierarchy resolution, same code for both lookups
    // --------------------------------------------------------------------
    logic [oem_pkg::ENG_W-1:0]  act    [NL];
    logic                       act_up [NL];
    logic                       act_ok [NL];
    logic                       is_rx  [NL];
    logic                       drop   [NL];
    logic                       extr   [NL];
    logic [NE-1:0]              hit_rx [NL];
    logic [NE-1:0]              hit_tx [NL];
    logic [NE-1:0]              hit_ds [NL];

    // one active engine per lookup updates every member once
    always_comb begin
        logic [oem_pkg::ENG_W-1:0]      a;
        logic [oem_pkg::ENG_W-1:0]      srv;
        logic [oem_pkg::ENG_W-1:0]      prt;
        logic [oem_pkg::ENG_W_BITS-1:0] c;
        logic [NE-1:0]                  mem;
        a   = '0;
        srv = '0;
        prt = '0;
        c   = '0;
        mem = '0;
        for (int l = 0; l < NL; l++) begin
            // no valid service index: fall through to the port engine
            if (lk_map_q[l]) begin
                a = lk_idx_q[l];
            end else begin
                a = oem_pkg::ENG_W'(lk_port_q[l]);
            end
            c         = eng_q[a];
            act[l]    = a;
            act_up[l] = c[oem_pkg::ENG_UP_BIT];
            act_ok[l] = lk_vld_q[l] && c[oem_pkg::ENG_ENA_BIT];
            // analyzer: receive for down, transmit for up; rewriter inverse
            is_rx[l]  = (l == 0) ? !act_up[l] : act_up[l];
            drop[l]   = act_ok[l] && lk_data_q[l]
                        && c[oem_pkg::ENG_DROP_BIT];
            extr[l]   = act_ok[l] && !lk_data_q[l] && is_rx[l]
                        && c[oem_pkg::ENG_EXTR_BIT];
            srv       = c[oem_pkg::ENG_SID_LSB +: oem_pkg::ENG_W];
            prt       = oem_pkg::ENG_W'(c[oem_pkg::ENG_RPORT_LSB +:
                                          oem_pkg::PORT_W]);
            mem       = '0;
            if (act_ok[l] && !drop[l]) begin
                // own counters only for data; members count everything
                mem[a] = lk_data_q[l];
                if (a >= oem_pkg::ENG_W'(oem_pkg::NUM_PORT)) begin
                    if (c[oem_pkg::ENG_LINK_BIT]
                        && eng_q[srv][oem_pkg::ENG_ENA_BIT]) begin
                        mem[srv] = 1'b1;
                    end
                    if (eng_q[prt][oem_pkg::ENG_ENA_BIT]) begin
                        mem[prt] = 1'b1;
                    end
                end
            end
            // a bit vector sets each engine once whatever the overlap
            hit_rx[l] = is_rx[l] ? mem : '0;
            hit_tx[l] = is_rx[l] ? '0 : mem;
            hit_ds[l] = '0;
            hit_ds[l][a] = drop[l];
        end
    end

    // --------------------------------------------------------------------
    // lookup results, registered
    // --------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_ana_done          <= 1'b0;
            o_ana_active_engine <= '0;
            o_ana_active_up     <= 1'b0;
            o_ana_processed     <= 1'b0;
            o_ana_discard       <= 1'b0;
            o_ana_extract       <= 1'b0;
            o_rew_done          <= 1'b0;
            o_rew_active_engine <= '0;
            o_rew_active_up     <= 1'b0;
            o_rew_processed     <= 1'b0;
            o_rew_discard       <= 1'b0;
            o_rew_extract       <= 1'b0;
        end else begin
            o_ana_done          <= lk_vld_q[0];
            o_ana_active_engine <= act[0];
            o_ana_active_up     <= act_up[0];
            o_ana_processed     <= act_ok[0];
            o_ana_discard       <= drop[0];
            o_ana_extract       <= extr[0];
            o_rew_done          <= lk_vld_q[1];
            o_rew_active_engine <= act[1];
            o_rew_active_up     <= act_up[1];
            o_rew_processed     <= act_ok[1];
            o_rew_discard       <= drop[1];
            o_rew_extract       <= extr[1];
        end
    end

    assign o_extract_queue = queue_q;

    // --------------------------------------------------------------------
    // avalon-mm slave, one wait state
    // --------------------------------------------------------------------
    logic                           ack_q;
    logic                           wr_go;
    logic [oem_pkg::ADDR_W-1:0]     wa;
    logic [oem_pkg::ADDR_W-1:0]     wbase;
    logic [oem_pkg::ENG_W-1:0]      widx;
    logic [31:0]                    rd_d;
    logic [31:0]                    rd_q;

    // request held until ack; write takes effect where waitrequest is low
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
    assign wr_go  = i_avs_write && ack_q;
    assign wa     = i_avs_address;
    assign wbase  = wa & ~oem_pkg::ADDR_W'({oem_pkg::TBL_SPAN_W{1'b1}});
    assign widx   = wa[2 +: oem_pkg::ENG_W];
    assign o_avs_readdata = rd_q;

    // decode one aligned word; unmapped reads give zero
    always_comb begin
        rd_d = 32'h0000_0000;
        case (wbase)
            oem_pkg::ADR_CTRL: begin
                if (wa == oem_pkg::ADR_CTRL) begin
                    rd_d = 32'(queue_q);
                end
            end
            oem_pkg::ADR_SVC:     rd_d = 32'(svc_q[widx]);
            oem_pkg::ADR_ENG:     rd_d = 32'(eng_q[widx]);
            oem_pkg::ADR_RX_CNT:  rd_d = rx_q[widx];
            oem_pkg::ADR_TX_CNT:  rd_d = tx_q[widx];
            oem_pkg::ADR_DSC_CNT: rd_d = dsc_q[widx];
            default:              rd_d = 32'h0000_0000;
        endcase
    end

    // ack pulses the cycle after a request appears
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
            rd_q  <= 32'h0000_0000;
        end else begin
            ack_q <= (i_avs_read || i_avs_write) && !ack_q;
            if (i_avs_read && !ack_q) begin
                rd_q <= rd_d;
            end
        end
    end

    // configuration writes; mapping consistency is software's duty
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            queue_q <= oem_pkg::QUEUE_RST;
            for (int e = 0; e < NE; e++) begin
                eng_q[e] <= oem_pkg::ENG_RST;
            end
            for (int s = 0; s < oem_pkg::NUM_SVC; s++) begin
                svc_q[s] <= '0;
            end
        end else if (wr_go) begin
            case (wbase)
                oem_pkg::ADR_CTRL: begin
                    if (wa == oem_pkg::ADR_CTRL) begin
                        queue_q <= i_avs_writedata[oem_pkg::CTRL_QUEUE_LSB
                                                   +: oem_pkg::QUEUE_W];
                    end
                end
                oem_pkg::ADR_SVC: begin
                    svc_q[widx] <= i_avs_writedata[oem_pkg::SVC_W:0];
                end
                oem_pkg::ADR_ENG: begin
                    eng_q[widx] <= i_avs_writedata[oem_pkg::ENG_W_BITS-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // loss and discard counters
    // --------------------------------------------------------------------
    logic wr_rx;
    logic wr_tx;
    logic wr_ds;

    assign wr_rx = wr_go && (wbase == oem_pkg::ADR_RX_CNT);
    assign wr_tx = wr_go && (wbase == oem_pkg::ADR_TX_CNT);
    assign wr_ds = wr_go && (wbase == oem_pkg::ADR_DSC_CNT);

    // both lookups may hit one engine in a cycle, so add both
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int e = 0; e < NE; e++) begin
                rx_q[e]  <= '0;
                tx_q[e]  <= '0;
                dsc_q[e] <= '0;
            end
        end else begin
            for (int e = 0; e < NE; e++) begin
                if (wr_rx && widx == oem_pkg::ENG_W'(e)) begin
                    rx_q[e] <= i_avs_writedata;
                end else begin
                    rx_q[e] <= rx_q[e] + oem_pkg::CNT_W'(hit_rx[0][e])
                               + oem_pkg::CNT_W'(hit_rx[1][e]);
                end
                if (wr_tx && widx == oem_pkg::ENG_W'(e)) begin
                    tx_q[e] <= i_avs_writedata;
                end else begin
                    tx_q[e] <= tx_q[e] + oem_pkg::CNT_W'(hit_tx[0][e])
                               + oem_pkg::CNT_W'(hit_tx[1][e]);
                end
                if (wr_ds && widx == oem_pkg::ENG_W'(e)) begin
                    dsc_q[e] <= i_avs_writedata;
                end else begin
                    dsc_q[e] <= dsc_q[e] + oem_pkg::CNT_W'(hit_ds[0][e])
                                + oem_pkg::CNT_W'(hit_ds[1][e]);
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** hw/oem_pkg.sv ***
package oem_pkg;
    // --------------------------------------------------------------------
    // sizes
    // --------------------------------------------------------------------
    localparam int NUM_ENG   = 16;  // engines 0..NUM_PORT-1 are port engines
    localparam int NUM_PORT  = 4;
    localparam int NUM_SVC   = 16;  // ingress service table entries
    localparam int ENG_W     = 4;
    localparam int PORT_W    = 2;
    localparam int SVC_W     = 4;
    localparam int QUEUE_W   = 3;
    localparam int CNT_W     = 32;
    localparam int ADDR_W    = 10;

    // --------------------------------------------------------------------
    // register map (byte addresses, one word each)
    // --------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADR_CTRL    = 10'h000;
    localparam logic [ADDR_W-1:0] ADR_SVC     = 10'h040; // +4*service_index
    localparam logic [ADDR_W-1:0] ADR_ENG     = 10'h080; // +4*engine
    localparam logic [ADDR_W-1:0] ADR_RX_CNT  = 10'h100; // +4*engine
    localparam logic [ADDR_W-1:0] ADR_TX_CNT  = 10'h140; // +4*engine
    localparam logic [ADDR_W-1:0] ADR_DSC_CNT = 10'h180; // +4*engine
    localparam int TBL_SPAN_W = 6;  // address bits spanned by one 16-word table (64 bytes)

    // control word: cpu queue for extracted receive pdus
    localparam int CTRL_QUEUE_LSB = 0;

    // service table word: endpoint_map_config
    localparam int SVC_IDX_LSB = 0;  // endpoint_index
    localparam int SVC_ENA_BIT = 4;  // endpoint_index_enable

    // engine word: engine_control and server_link_config
    localparam int ENG_ENA_BIT     = 0;  // engine enable
    localparam int ENG_UP_BIT      = 1;  // up-facing
    localparam int ENG_SERVER_BIT  = 2;  // engine_is_server
    localparam int ENG_LINK_BIT    = 3;  // server_link_enable
    localparam int ENG_DROP_BIT    = 4;  // discard data frames
    localparam int ENG_EXTR_BIT    = 5;  // extract receive oam pdus
    localparam int ENG_SID_LSB     = 8;  // server_engine_id
    localparam int ENG_RPORT_LSB   = 12; // resident port
    localparam int ENG_W_BITS      = 14;

    localparam logic [ENG_W_BITS-1:0] ENG_RST = 14'h0000;
    localparam logic [QUEUE_W-1:0]    QUEUE_RST = 3'h0;
endpackage

// *** testbench/oem_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// lookup timing and result checks at the top ports
// ----------------------------------------------------------------
module oem_checker (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic       i_ana_valid,
    input wire logic       i_ana_independent_level_flag,
    input wire logic       i_rew_valid,
    input wire logic [1:0] i_rew_port,
    input wire logic       i_rew_egress_endpoint_index_valid,
    input wire logic [3:0] i_rew_egress_endpoint_index,
    input wire logic       o_ana_done,
    input wire logic       o_ana_active_up,
    input wire logic       o_ana_processed,
    input wire logic       o_ana_discard,
    input wire logic       o_ana_extract,
    input wire logic       o_rew_done,
    input wire logic [3:0] o_rew_active_engine,
    input wire logic       o_rew_active_up,
    input wire logic       o_rew_extract
);
    // single domain, so one clock and one disable for all
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    a_ana_answer: assert property (
        i_ana_valid |-> ##2 o_ana_done) else $error("analyzer done late");
    a_ana_single: assert property (
        o_ana_done |-> $past(i_ana_valid, 2)) else $error("spurious done");
    a_rew_answer: assert property (
        i_rew_valid |-> ##2 o_rew_done) else $error("rewriter done late");
    // unmapped frames must land on the engine numbered like the port
    a_rew_port_fall: assert property (
        i_rew_valid && !i_rew_egress_endpoint_index_valid |-> ##2
        (o_rew_active_engine == {2'h0, $past(i_rew_port, 2)}))
        else $error("rewriter port fallback wrong");
    a_rew_index: assert property (
        i_rew_valid && i_rew_egress_endpoint_index_valid |-> ##2
        (o_rew_active_engine == $past(i_rew_egress_endpoint_index, 2)))
        else $error("rewriter index not used");
    a_discard_enabled: assert property (
        o_ana_discard |-> o_ana_processed) else $error("disabled discard");
    a_ana_extract_down: assert property (
        o_ana_extract |-> o_ana_done && !o_ana_active_up)
        else $error("analyzer extract not receive");
    a_rew_extract_up: assert property (
        o_rew_extract |-> o_rew_done && o_rew_active_up)
        else $error("rewriter extract not receive");
    a_level_as_data: assert property (
        i_ana_valid && i_ana_independent_level_flag |-> ##2 !o_ana_extract)
        else $error("independent level pdu extracted");
endmodule

bind oem_top oem_checker oem_checker_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ana_valid(i_ana_valid),
    .i_ana_independent_level_flag(i_ana_independent_level_flag),
    .i_rew_valid(i_rew_valid), .i_rew_port(i_rew_port),
    .i_rew_egress_endpoint_index_valid(i_rew_egress_endpoint_index_valid),
    .i_rew_egress_endpoint_index(i_rew_egress_endpoint_index),
    .o_ana_done(o_ana_done), .o_ana_active_up(o_ana_active_up),
    .o_ana_processed(o_ana_processed), .o_ana_discard(o_ana_discard),
    .o_ana_extract(o_ana_extract), .o_rew_done(o_rew_done),
    .o_rew_active_engine(o_rew_active_engine),
    .o_rew_active_up(o_rew_active_up), .o_rew_extract(o_rew_extract));
`default_nettype wire

// *** testbench/oem_lookup_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// analyzer and rewriter lookup stages in front of the block
// ----------------------------------------------------------------
module oem_lookup_model (
    input  wire logic       i_clk_sys,
    output logic            o_ana_valid,
    output logic [1:0]      o_ana_port,
    output logic [3:0]      o_ana_svc,
    output logic            o_ana_oam,
    output logic            o_ana_ind,
    output logic            o_rew_valid,
    output logic [1:0]      o_rew_port,
    output logic            o_rew_iv,
    output logic [3:0]      o_rew_idx,
    output logic            o_rew_oam,
    output logic            o_rew_ind
);
    // quiet stages at time zero
    initial begin
        {o_ana_valid, o_ana_port, o_ana_svc, o_ana_oam, o_ana_ind} = '0;
        {o_rew_valid, o_rew_port, o_rew_iv, o_rew_idx} = '0;
        {o_rew_oam, o_rew_ind} = '0;
    end
    // one-cycle lookup; fields inverted after it so none pass as stale
    task automatic ana_go(input logic [1:0] p, input logic [3:0] s,
                          input logic oam, input logic ind);
        @(posedge i_clk_sys);
        o_ana_valid <= 1'b1;
        {o_ana_port, o_ana_svc, o_ana_oam, o_ana_ind} <= {p, s, oam, ind};
        @(posedge i_clk_sys);
        o_ana_valid <= 1'b0;
        {o_ana_port, o_ana_svc, o_ana_oam, o_ana_ind} <= ~{p, s, oam, ind};
    endtask
    // injected pdus arrive flagged on the lookup, not as port traffic
    task automatic rew_go(input logic [1:0] p, input logic v,
                          input logic [3:0] i, input logic oam,
                          input logic ind);
        @(posedge i_clk_sys);
        o_rew_valid <= 1'b1;
        {o_rew_port, o_rew_iv, o_rew_idx} <= {p, v, i};
        {o_rew_oam, o_rew_ind} <= {oam, ind};
        @(posedge i_clk_sys);
        o_rew_valid <= 1'b0;
        {o_rew_port, o_rew_iv, o_rew_idx} <= ~{p, v, i};
        {o_rew_oam, o_rew_ind} <= ~{oam, ind};
    endtask
endmodule
`default_nettype wire

// *** testbench/oem_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module oem_top_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rd_s = 1'b0;
    logic        wr_s = 1'b0;
    logic [9:0]  adr = '0;
    logic [31:0] wdat = '0;
    wire  [31:0] rdat;
    wire         wait_r, av, ao, ai, rv, riv, ro, rin;
    wire  [1:0]  ap, rp;
    wire  [3:0]  asv, ri;
    wire  [8:0]  a_res, r_res;
    wire  [2:0]  q;
    logic [13:0] cfg [16] = '{default: '0};
    logic [4:0]  svc [16] = '{default: '0};
    logic [31:0] e_cnt [3][16] = '{default: '{default: '0}};
    logic [2:0]  queue_q = 3'h0;
    int          err_count = 0;
    int          num_checks = 0;

    always #25 clk = ~clk;

    oem_lookup_model oem_lookup_model_i (.i_clk_sys(clk),
        .o_ana_valid(av), .o_ana_port(ap), .o_ana_svc(asv), .o_ana_oam(ao),
        .o_ana_ind(ai), .o_rew_valid(rv), .o_rew_port(rp), .o_rew_iv(riv),
        .o_rew_idx(ri), .o_rew_oam(ro), .o_rew_ind(rin));
    oem_top oem_top_i (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_r), .i_ana_valid(av), .i_ana_port(ap),
        .i_ana_service_index(asv), .i_ana_is_oam(ao),
        .i_ana_independent_level_flag(ai), .i_rew_valid(rv),
        .i_rew_port(rp), .i_rew_egress_endpoint_index_valid(riv),
        .i_rew_egress_endpoint_index(ri), .i_rew_is_oam(ro),
        .i_rew_independent_level_flag(rin), .o_ana_done(a_res[8]),
        .o_ana_active_engine(a_res[7:4]), .o_ana_active_up(a_res[3]),
        .o_ana_processed(a_res[2]), .o_ana_discard(a_res[1]),
        .o_ana_extract(a_res[0]), .o_rew_done(r_res[8]),
        .o_rew_active_engine(r_res[7:4]), .o_rew_active_up(r_res[3]),
        .o_rew_processed(r_res[2]), .o_rew_discard(r_res[1]),
        .o_rew_extract(r_res[0]), .o_extract_queue(q));

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input bit w, input logic [9:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        {adr, wdat, wr_s, rd_s} <= {a, d, w, !w};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wait_r === 1'b0) break;
        end
        r = rdat;
        {wr_s, rd_s} <= 2'b00;
        if (n == 20) begin
            err_count++;
            wrap_up;
        end
    endtask
    function automatic logic [13:0] ew(bit en, up, srv, lnk, drp, ext,
                                       logic [3:0] sid, logic [1:0] rpt);
        return {rpt, sid, 2'b00, ext, drp, lnk, srv, up, en};
    endfunction
    task automatic set_eng(input int e, input logic [13:0] c);
        logic [31:0] r;
        bus(1, oem_pkg::ADR_ENG + 10'(4 * e), {18'h0, c}, r);
        cfg[e] = c;
    endtask
    // every counter of every engine against the running expectation
    task automatic check_all;
        logic [31:0] r;
        for (int b = 0; b < 3; b++)
            for (int e = 0; e < 16; e++) begin
                bus(0, oem_pkg::ADR_RX_CNT + 10'(64 * b + 4 * e), 0, r);
                chk($sformatf("cnt%0d_%0d", b, e), r, e_cnt[b][e]);
            end
    endtask
    // one lookup, judged against the hierarchy rules, then counted
    task automatic look(input bit w, input logic [1:0] p,
                        input logic [3:0] s, input bit v, oam, ind);
        logic [3:0]  a;
        logic [13:0] c;
        logic        dat, rx, pr, ds, ex;
        int          d;
        a = w ? (v ? s : {2'h0, p}) : (svc[s][4] ? svc[s][3:0] : {2'h0, p});
        c = cfg[a];
        pr = c[0];
        dat = !oam || ind;
        rx = w ? c[1] : !c[1];
        ds = pr && c[4] && dat;
        ex = pr && oam && !ind && rx && c[5];
        d = rx ? 0 : 1;
        if (w) oem_lookup_model_i.rew_go(p, v, s, oam, ind);
        else oem_lookup_model_i.ana_go(p, s, oam, ind);
        @(posedge clk);
        #1;
        chk("result", w ? r_res : a_res, {1'b1, a, c[1], pr, ds, ex});
        if (ex) chk("queue", q, queue_q);
        if (ds) e_cnt[2][a]++;
        else if (pr) begin
            if (dat) e_cnt[d][a]++;
            if (a >= 4) begin
                if (c[3] && cfg[c[11:8]][0]) e_cnt[d][c[11:8]]++;
                if (cfg[c[13:12]][0]) e_cnt[d][c[13:12]]++;
            end
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        bus(0, oem_pkg::ADR_ENG + 10'h01C, 0, r);
        chk("eng_rst", r, {18'h0, oem_pkg::ENG_RST});
        bus(1, 10'h3FC, 32'hFFFF_FFFF, r);
        bus(0, 10'h3FC, 0, r);
        chk("unmapped", r, 32'h0);
        bus(1, oem_pkg::ADR_CTRL, 32'h5, r);
        queue_q = 3'h5;
        bus(0, oem_pkg::ADR_CTRL, 0, r);
        chk("ctrl", r, 32'h5);
        $display("test regs done");
    endtask
    // unmapped traffic on a disabled, then enabled port engine
    task automatic t_port;
        look(0, 2'h2, 4'h0, 0, 0, 0);
        set_eng(2, ew(1, 0, 0, 0, 0, 0, 4'h0, 2'h2));
        look(0, 2'h2, 4'h0, 0, 0, 0);
        look(1, 2'h2, 4'h9, 0, 0, 0);
        look(1, 2'h2, 4'h9, 0, 1, 0);
        check_all;
        $display("test port done");
    endtask
    // service engine 5 with server 6, both resident on port 1
    task automatic t_hier;
        logic [31:0] r;
        set_eng(1, ew(1, 0, 0, 0, 0, 0, 4'h0, 2'h1));
        set_eng(6, ew(1, 1, 1, 0, 0, 0, 4'h0, 2'h1));
        set_eng(5, ew(1, 1, 0, 1, 0, 1, 4'h6, 2'h1));
        bus(1, oem_pkg::ADR_SVC + 10'h00C, 32'h15, r);
        svc[3] = 5'h15;
        for (int i = 0; i < 6; i++)
            look(i >= 3, 2'h1, i >= 3 ? 4'h5 : 4'h3, 1, i % 3 != 0,
                 i % 3 == 2);
        look(1, 2'h1, 4'h6, 1, 0, 0);
        set_eng(5, ew(1, 1, 0, 0, 0, 1, 4'h6, 2'h1));
        look(0, 2'h1, 4'h3, 0, 0, 0);
        check_all;
        $display("test hierarchy done");
    endtask
    // down engine 7 dropping data while its pdus are extracted
    task automatic t_drop;
        logic [31:0] r;
        set_eng(3, ew(1, 0, 0, 0, 0, 0, 4'h0, 2'h3));
        set_eng(7, ew(1, 0, 0, 0, 1, 1, 4'h0, 2'h3));
        bus(1, oem_pkg::ADR_SVC + 10'h010, 32'h17, r);
        svc[4] = 5'h17;
        look(0, 2'h3, 4'h4, 0, 0, 0);
        look(0, 2'h3, 4'h4, 0, 1, 0);
        look(1, 2'h3, 4'h7, 1, 1, 0);
        look(0, 2'h3, 4'h4, 0, 1, 1);
        bus(1, oem_pkg::ADR_DSC_CNT + 10'h01C, 32'h0000_0100, r);
        e_cnt[2][7] = 32'h0000_0100;
        check_all;
        $display("test discard done");
    endtask

    // reset for 20 cycles, then the scenarios in order
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_port;
        t_hier;
        t_drop;
        wrap_up;
    end
endmodule
`default_nettype wire
